// ===== rtl/boot_config_pkg.sv
// Purpose: Constants and types for the boot configuration decoder
// Assumes: 50 MHz core clock, halfword bit 0 is the most significant bit
// Notes: Halfword fields are kept as bit positions of a 16-bit word
package boot_config_pkg;
    localparam int CLK_FREQ_HZ = 50000000;
    localparam int HALFWORD_W = 16;
    localparam int BLOCK_IDX_W = 2;
    localparam int NUM_BLOCKS = 4;
    localparam int BAUD_CNT_W = 20;
    localparam int SETTLE_W = 2;
    localparam logic [SETTLE_W-1:0] SETTLE_CYCLES = 2'h3;

    // Halfword field positions (halfword bit 0 is bit 15 here)
    localparam int RSVD_MSB = 15;
    localparam int RSVD_LSB = 12;
    localparam int SOFT_WDOG_BIT = 11;
    localparam int CORE_WDOG_BIT = 10;
    localparam int PORT_WIDTH_BIT = 9;
    localparam int CODE_SEL_BIT = 8;
    localparam int SIG_MSB = 7;
    localparam int SIG_LSB = 0;
    localparam logic [7:0] VALID_SIGNATURE = 8'h5A;

    // Watchdog timeouts in system clocks
    localparam logic [31:0] SOFT_WDOG_TIMEOUT = 32'h0003FDE0;
    // 2.5 x 2^17 clocks
    localparam logic [31:0] CORE_WDOG_TIMEOUT = 32'h00050000;

    // Boot source pin encodings
    localparam logic [1:0] SRC_INTERNAL = 2'h0;
    localparam logic [1:0] SRC_SERIAL = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;

    // Values after reset
    localparam logic RST_SOFT_WDOG_EN = 1'b1;
    localparam logic RST_CORE_WDOG_EN = 1'b1;
    localparam logic RST_PORT_16BIT = 1'b1;
    localparam logic RST_CODE_SEL = 1'b0;
    localparam logic [BAUD_CNT_W-1:0] RST_BAUD = 20'h00000;

    typedef enum logic [3:0] {
        ST_SETTLE = 4'b0000,
        ST_DECIDE = 4'b0001,
        ST_FETCH = 4'b0010,
        ST_CHECK = 4'b0011,
        ST_SERIAL = 4'b0100,
        ST_WAIT_FALL = 4'b0101,
        ST_MEASURE = 4'b0110,
        ST_START = 4'b0111,
        ST_RUN = 4'b1000,
        ST_ERROR = 4'b1001
    } boot_state_type;
endpackage

// ===== rtl/boot_config_word_decoder.sv
// Purpose: Boot assist logic: boot source choice, autobaud, config halfword decode
// Assumes: Synchronous active-high reset; pins are asynchronous to core_clk_in
// Notes: Halfword fetch port is same-clock logic, held request until valid
//
// Summary of operation
// - Sampled sense pin: 0 fixed-rate serial boot, 1 autobaud serial boot.
// - Autobaud status output shows the sampled sense pin level on serial boot; it stays 0 on internal or external boot.
// - Soft watchdog disabled by halfword: accesses unmapped, raise an exception.
// - Soft watchdog enabled by halfword: writing enable 0 disables it.
// - Halfword bits 0-3 ignored; writer should program them zero.
// - Soft watchdog bit clear disables it; set keeps 261600-clock timeout.
// - Core watchdog bit 0 disables it; 1 keeps 2.5 x 2^17 clock timeout.
// - After reset first chip select is a 16-bit port.
// - Port width bit after fetch: 0 gives 32-bit port, 1 gives 16-bit.
// - Code select bit marks translation entries 1-3 classic or compact code.
// - Block is valid only when its signature field equals 0x5A.
// - Internal boot checks blocks 0-3 in turn until one has a valid signature; external boot checks block 0 only.
// - Boot source pins: 00 internal, 01 serial, 10 external, 11 reserved.
`timescale 1ns/100ps
module boot_config_word_decoder
    import boot_config_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [1:0] boot_source_pins_in,
    input wire logic boot_mode_sense_pin_in,
    input wire logic serial_rx_in,
    input wire logic fetch_valid_in,
    input wire logic [HALFWORD_W-1:0] fetch_data_in,
    input wire logic wdog_access_in,
    input wire logic wdog_write_in,
    input wire logic wdog_enable_wdata_in,
    output logic fetch_req_out,
    output logic fetch_external_out,
    output logic [BLOCK_IDX_W-1:0] fetch_block_out,
    output logic serial_boot_out,
    output logic autobaud_status_bit_out,
    output logic [BAUD_CNT_W-1:0] baud_count_out,
    output logic baud_valid_out,
    output logic chip_select_zero_16bit_out,
    output logic compact_code_select_out,
    output logic soft_watchdog_enable_out,
    output logic soft_watchdog_mapped_out,
    output logic [31:0] soft_watchdog_timeout_out,
    output logic core_watchdog_enable_out,
    output logic [31:0] core_watchdog_timeout_out,
    output logic watchdog_exception_out,
    output logic user_start_out,
    output logic boot_done_out,
    output logic boot_error_out
);

    //------------------------------------------------------------
    // Pin synchronisers
    //------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [1:0] src_sync;
    logic sense_sync;
    logic rx_sync;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sync1_reg <= 4'hF;
            sync2_reg <= 4'hF;
        end else begin
            sync1_reg <= {serial_rx_in, boot_mode_sense_pin_in, boot_source_pins_in};
            sync2_reg <= sync1_reg;
        end
    end

    assign src_sync = sync2_reg[1:0];
    assign sense_sync = sync2_reg[2];
    assign rx_sync = sync2_reg[3];

    //------------------------------------------------------------
    // Halfword decode helpers
    //------------------------------------------------------------
    function automatic logic sig_ok(input logic [HALFWORD_W-1:0] hw);
        sig_ok = (hw[SIG_MSB:SIG_LSB] == VALID_SIGNATURE);
    endfunction

    //------------------------------------------------------------
    // Boot sequencer state
    //------------------------------------------------------------
    boot_state_type state_reg, state_next;
    logic [SETTLE_W-1:0] settle_reg, settle_next;
    logic [BLOCK_IDX_W-1:0] block_reg, block_next;
    logic external_reg, external_next;
    logic [HALFWORD_W-1:0] hw_reg, hw_next;
    logic rx_prev_reg, rx_prev_next;
    logic [BAUD_CNT_W-1:0] baud_reg, baud_next;
    logic baud_valid_reg, baud_valid_next;
    logic serial_reg, serial_next;
    logic autobaud_reg, autobaud_next;
    logic port16_reg, port16_next;
    logic code_sel_reg, code_sel_next;
    logic soft_en_reg, soft_en_next;
    logic soft_map_reg, soft_map_next;
    logic core_en_reg, core_en_next;
    logic exc_reg, exc_next;
    logic start_reg, start_next;
    logic error_reg, error_next;

    always_comb begin
        state_next = state_reg;
        settle_next = settle_reg;
        block_next = block_reg;
        external_next = external_reg;
        hw_next = hw_reg;
        rx_prev_next = rx_sync;
        baud_next = baud_reg;
        baud_valid_next = baud_valid_reg;
        serial_next = serial_reg;
        autobaud_next = autobaud_reg;
        port16_next = port16_reg;
        code_sel_next = code_sel_reg;
        soft_en_next = soft_en_reg;
        soft_map_next = soft_map_reg;
        core_en_next = core_en_reg;
        exc_next = 1'b0;
        start_next = 1'b0;
        error_next = error_reg;
        case (state_reg)
            ST_SETTLE: begin
                if (settle_reg == SETTLE_CYCLES) begin
                    state_next = ST_DECIDE;
                end else begin
                    settle_next = settle_reg + 1'b1;
                end
            end
            ST_DECIDE: begin
                port16_next = RST_PORT_16BIT;
                block_next = '0;
                if (src_sync == SRC_INTERNAL) begin
                    external_next = 1'b0;
                    state_next = ST_FETCH;
                end else if (src_sync == SRC_EXTERNAL) begin
                    external_next = 1'b1;
                    state_next = ST_FETCH;
                end else if (src_sync == SRC_SERIAL) begin
                    state_next = ST_SERIAL;
                end else begin
                    error_next = 1'b1;
                    state_next = ST_ERROR;
                end
            end
            ST_FETCH: begin
                if (fetch_valid_in) begin
                    hw_next = fetch_data_in;
                    state_next = ST_CHECK;
                end
            end
            ST_CHECK: begin
                if (sig_ok(hw_reg)) begin
                    // Reserved bits RSVD_MSB..RSVD_LSB are not looked at
                    soft_en_next = hw_reg[SOFT_WDOG_BIT];
                    soft_map_next = hw_reg[SOFT_WDOG_BIT];
                    core_en_next = hw_reg[CORE_WDOG_BIT];
                    port16_next = hw_reg[PORT_WIDTH_BIT];
                    code_sel_next = hw_reg[CODE_SEL_BIT];
                    start_next = 1'b1;
                    state_next = ST_RUN;
                end else if (!external_reg && (block_reg != BLOCK_IDX_W'(NUM_BLOCKS - 1))) begin
                    block_next = block_reg + 1'b1;
                    state_next = ST_FETCH;
                end else begin
                    state_next = ST_SERIAL;
                end
            end
            ST_SERIAL: begin
                serial_next = 1'b1;
                autobaud_next = sense_sync;
                if (sense_sync) begin
                    state_next = ST_WAIT_FALL;
                end else begin
                    start_next = 1'b1;
                    state_next = ST_RUN;
                end
            end
            ST_WAIT_FALL: begin
                if (rx_prev_reg && !rx_sync) begin
                    baud_next = BAUD_CNT_W'(1);
                    state_next = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (rx_sync) begin
                    baud_valid_next = 1'b1;
                    start_next = 1'b1;
                    state_next = ST_RUN;
                end else if (baud_reg != '1) begin
                    baud_next = baud_reg + 1'b1;
                end
            end
            ST_RUN: begin
                if (wdog_access_in && !soft_map_reg) begin
                    exc_next = 1'b1;
                end else if (wdog_access_in && wdog_write_in && !wdog_enable_wdata_in) begin
                    soft_en_next = 1'b0;
                end
            end
            ST_ERROR: begin
                error_next = 1'b1;
            end
            default: begin
                state_next = ST_ERROR;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_reg <= ST_SETTLE;
            settle_reg <= '0;
            block_reg <= '0;
            external_reg <= 1'b0;
            hw_reg <= '0;
            rx_prev_reg <= 1'b1;
            baud_reg <= RST_BAUD;
            baud_valid_reg <= 1'b0;
            serial_reg <= 1'b0;
            autobaud_reg <= 1'b0;
            port16_reg <= RST_PORT_16BIT;
            code_sel_reg <= RST_CODE_SEL;
            soft_en_reg <= RST_SOFT_WDOG_EN;
            soft_map_reg <= 1'b1;
            core_en_reg <= RST_CORE_WDOG_EN;
            exc_reg <= 1'b0;
            start_reg <= 1'b0;
            error_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            settle_reg <= settle_next;
            block_reg <= block_next;
            external_reg <= external_next;
            hw_reg <= hw_next;
            rx_prev_reg <= rx_prev_next;
            baud_reg <= baud_next;
            baud_valid_reg <= baud_valid_next;
            serial_reg <= serial_next;
            autobaud_reg <= autobaud_next;
            port16_reg <= port16_next;
            code_sel_reg <= code_sel_next;
            soft_en_reg <= soft_en_next;
            soft_map_reg <= soft_map_next;
            core_en_reg <= core_en_next;
            exc_reg <= exc_next;
            start_reg <= start_next;
            error_reg <= error_next;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign fetch_req_out = (state_reg == ST_FETCH);
    assign fetch_external_out = external_reg;
    assign fetch_block_out = block_reg;
    assign serial_boot_out = serial_reg;
    assign autobaud_status_bit_out = autobaud_reg;
    assign baud_count_out = baud_reg;
    assign baud_valid_out = baud_valid_reg;
    assign chip_select_zero_16bit_out = port16_reg;
    assign compact_code_select_out = code_sel_reg;
    assign soft_watchdog_enable_out = soft_en_reg;
    assign soft_watchdog_mapped_out = soft_map_reg;
    assign soft_watchdog_timeout_out = SOFT_WDOG_TIMEOUT;
    assign core_watchdog_enable_out = core_en_reg;
    assign core_watchdog_timeout_out = CORE_WDOG_TIMEOUT;
    assign watchdog_exception_out = exc_reg;
    assign user_start_out = start_reg;
    assign boot_done_out = (state_reg == ST_RUN);
    assign boot_error_out = error_reg;

endmodule

// ===== bench/boot_config_chk.sv
// Purpose: Port-level checks for the boot configuration decoder
// Assumes: One clock domain, synchronous active-high reset
// Notes: Halfword taken at the edge where request and valid meet
`timescale 1ns/100ps
module boot_config_chk
    import boot_config_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic fetch_req_out,
    input wire logic fetch_valid_in,
    input wire logic [HALFWORD_W-1:0] fetch_data_in,
    input wire logic wdog_access_in,
    input wire logic wdog_write_in,
    input wire logic wdog_enable_wdata_in,
    input wire logic boot_done_out,
    input wire logic user_start_out,
    input wire logic soft_watchdog_mapped_out,
    input wire logic soft_watchdog_enable_out,
    input wire logic core_watchdog_enable_out,
    input wire logic chip_select_zero_16bit_out,
    input wire logic compact_code_select_out,
    input wire logic watchdog_exception_out,
    input wire logic baud_valid_out,
    input wire logic serial_boot_out,
    input wire logic autobaud_status_bit_out,
    input wire logic boot_error_out,
    input wire logic [31:0] soft_watchdog_timeout_out,
    input wire logic [31:0] core_watchdog_timeout_out
);
    // ----
    // Checks
    // ----
    logic take;
    logic [HALFWORD_W-1:0] cfg_q;
    assign take = fetch_req_out && fetch_valid_in;
    always_ff @(posedge core_clk_in) begin
        if (take) begin
            cfg_q <= fetch_data_in;
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    reset_defaults_a: assert property ($past(rst_in) |-> chip_select_zero_16bit_out && soft_watchdog_enable_out
        && core_watchdog_enable_out && !user_start_out) else $error("outputs not at reset values");
    timeout_values_a: assert property (soft_watchdog_timeout_out == 32'h0003FDE0
        && core_watchdog_timeout_out == 32'h00050000) else $error("watchdog timeout wrong");
    sig_start_a: assert property (take && fetch_data_in[7:0] == 8'h5A |-> ##2 user_start_out && boot_done_out)
        else $error("valid signature did not start user code");
    config_apply_a: assert property (take && fetch_data_in[7:0] == 8'h5A |-> ##2 soft_watchdog_mapped_out ==
        cfg_q[11] && {core_watchdog_enable_out, chip_select_zero_16bit_out, compact_code_select_out} == cfg_q[10:8])
        else $error("halfword options not applied");
    unmapped_exc_a: assert property (boot_done_out && wdog_access_in && !soft_watchdog_mapped_out
        |=> watchdog_exception_out) else $error("no exception on unmapped access");
    wdog_off_a: assert property (boot_done_out && wdog_access_in && wdog_write_in && !wdog_enable_wdata_in
        && soft_watchdog_mapped_out |=> !soft_watchdog_enable_out) else $error("watchdog not disabled");
    baud_start_a: assert property ($rose(baud_valid_out) |-> user_start_out && serial_boot_out
        && autobaud_status_bit_out) else $error("baud result without autobaud start");
    reserved_halt_a: assert property (boot_error_out |-> !fetch_req_out && !serial_boot_out
        && !user_start_out) else $error("reserved source did not halt");
endmodule
bind boot_config_word_decoder boot_config_chk chk (.*);

// ===== bench/boot_host_model.sv
// Purpose: Boot memory and serial host model
// Assumes: Same clock as the decoder, serial line idles high
// Notes: Data bus shows inverted last word when released
`timescale 1ns/100ps
module boot_host_model
    import boot_config_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic fetch_req_out,
    input wire logic [BLOCK_IDX_W-1:0] fetch_block_out,
    input wire logic serial_boot_out,
    input wire logic [HALFWORD_W-1:0] words_in [NUM_BLOCKS],
    input wire logic [3:0] wait_in,
    input wire logic [7:0] low_len_in,
    output logic fetch_valid_in = 1'b0,
    output logic [HALFWORD_W-1:0] fetch_data_in = 16'h0000,
    output logic serial_rx_in = 1'b1
);
    int w;
    int lo;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            fetch_valid_in <= 1'b0;
            serial_rx_in <= 1'b1;
            w = 0;
            lo = 0;
        end else begin
            if (fetch_valid_in && fetch_req_out) begin
                fetch_valid_in <= 1'b0;
                fetch_data_in <= ~fetch_data_in;
            end else if (fetch_req_out && !fetch_valid_in) begin
                w = w + 1;
                if (w > wait_in) begin
                    fetch_valid_in <= 1'b1;
                    fetch_data_in <= words_in[fetch_block_out];
                    w = 0;
                end
            end
            // Empty frame first: line low for low_len_in cycles
            if (serial_boot_out) begin
                lo = lo + 1;
            end
            serial_rx_in <= !(lo > 3 && lo <= 3 + low_len_in);
        end
    end
endmodule

// ===== bench/testbench.sv
// Purpose: Self-checking bench for the boot configuration decoder
// Assumes: Reset held 6 cycles before each boot
// Notes: Expected outcome recomputed from the halfword table
`timescale 1ns/100ps
module testbench
    import boot_config_pkg::*;
;
    logic core_clk_in = 1'b0, rst_in = 1'b1, serial_rx_in, fetch_valid_in;
    logic boot_mode_sense_pin_in = 1'b0, wdog_access_in = 1'b0, wdog_write_in = 1'b0, wdog_enable_wdata_in = 1'b0;
    logic [1:0] boot_source_pins_in = 2'h0;
    logic [HALFWORD_W-1:0] fetch_data_in;
    logic fetch_req_out, fetch_external_out, serial_boot_out, autobaud_status_bit_out, baud_valid_out;
    logic chip_select_zero_16bit_out, compact_code_select_out, soft_watchdog_enable_out, soft_watchdog_mapped_out;
    logic core_watchdog_enable_out, watchdog_exception_out, user_start_out, boot_done_out, boot_error_out;
    logic [BLOCK_IDX_W-1:0] fetch_block_out;
    logic [BAUD_CNT_W-1:0] baud_count_out;
    logic [31:0] soft_watchdog_timeout_out, core_watchdog_timeout_out;
    logic [HALFWORD_W-1:0] words_in [NUM_BLOCKS];
    logic [3:0] wait_in = 4'h0;
    logic [7:0] low_len_in = 8'h10, lf = 8'h56;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    always #10 core_clk_in = ~core_clk_in;
    boot_config_word_decoder dut (.*);
    boot_host_model host (.*);
    // ----
    // Tasks
    // ----
    function automatic logic [7:0] nx(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wd(input logic wr, input logic d);
        @(posedge core_clk_in);
        wdog_access_in <= 1'b1;
        wdog_write_in <= wr;
        wdog_enable_wdata_in <= d;
        @(posedge core_clk_in);
        wdog_access_in <= 1'b0;
        #1;
    endtask
    task automatic boot(input logic [1:0] src, input logic sense);
        int n, b, lim;
        logic [3:0] cfg;
        @(posedge core_clk_in);
        boot_source_pins_in <= src;
        boot_mode_sense_pin_in <= sense;
        rst_in <= 1'b1;
        repeat (6) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        check("reset_port", chip_select_zero_16bit_out, 1'b1);
        n = 0;
        while (user_start_out !== 1'b1 && boot_error_out !== 1'b1 && n < 3000) begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        b = -1;
        lim = (src == SRC_INTERNAL) ? NUM_BLOCKS : (src == SRC_EXTERNAL);
        for (int i = 0; i < lim; i++)
            if (b < 0 && words_in[i][7:0] == VALID_SIGNATURE)
                b = i;
        check("error", boot_error_out, src == SRC_RESERVED);
        if (src == SRC_RESERVED)
            return;
        check("started", user_start_out, 1'b1);
        check("serial", serial_boot_out, b < 0);
        if (b >= 0) begin
            cfg = {soft_watchdog_enable_out, core_watchdog_enable_out, chip_select_zero_16bit_out, compact_code_select_out};
            check("source", fetch_external_out, src == SRC_EXTERNAL);
            check("block", fetch_block_out, b);
            check("config", cfg, words_in[b][11:8]);
        end else begin
            check("autobaud", autobaud_status_bit_out, sense);
            check("defaults", {soft_watchdog_enable_out, core_watchdog_enable_out}, 2'h3);
            if (sense)
                check("baud", baud_count_out, low_len_in);
        end
    endtask
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        words_in = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
        lf = nx(lf);
        words_in = '{{lf[3:0], 12'hF5A}, 16'h0000, 16'h0000, 16'h0000};
        boot(SRC_INTERNAL, 1'b0);
        wd(1'b0, 1'b0);
        check("exc_mapped", watchdog_exception_out, 1'b0);
        wd(1'b1, 1'b0);
        check("soft_off", soft_watchdog_enable_out, 1'b0);
        lf = nx(lf);
        wait_in = 4'h3;
        words_in = '{16'h0F00, {lf[3:0], 12'hF5B}, {lf[7:4], 12'h05A}, 16'h0F5A};
        boot(SRC_INTERNAL, 1'b1);
        check("mapped", soft_watchdog_mapped_out, 1'b0);
        wd(1'b1, 1'b1);
        check("exc_unmapped", watchdog_exception_out, 1'b1);
        words_in = '{16'h0F00, 16'h0F01, 16'h0F02, 16'h0F03};
        boot(SRC_INTERNAL, 1'b0);
        lf = nx(lf);
        low_len_in = {2'h0, lf[5:0]} + 8'h04;
        boot(SRC_SERIAL, 1'b1);
        lf = nx(lf);
        wait_in = 4'h5;
        words_in = '{{4'h0, lf[3:0], 8'h5A}, 16'h0000, 16'h0000, 16'h0000};
        boot(SRC_EXTERNAL, 1'b0);
        words_in[0] = 16'h0F5B;
        boot(SRC_EXTERNAL, 1'b0);
        boot(SRC_RESERVED, 1'b0);
        stop_test();
    end
endmodule
